//--- rtl/cpt_pkg.sv
// constants, types and carriers for the can link ping-pong tester.
// assumes a single 100 MHz system clock and a can controller on that clock.
package cpt_pkg;

    // timing, in the unit printed, and derived cycle counts
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned TIMEOUT_MS     = 1000;
    localparam int unsigned HALF_BLINK_MS  = 500;
    localparam int unsigned TIMEOUT_CYC    = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned HALF_BLINK_CYC = HALF_BLINK_MS * 1000 * CLK_MHZ;
    localparam int          TMR_W          = 27;    // holds 1e8 cycles

    // power-up settle: cycles for the strap synchronisers to fill
    localparam logic [1:0]  SETTLE_CYC     = 2'h3;

    // burst: four blinks are eight half periods
    localparam logic [3:0]  BURST_HALVES   = 4'h8;
    localparam int          NUM_BURST      = 3;
    localparam int          B_ERR          = 0;     // timeout error led
    localparam int          B_CAN          = 1;     // can error led
    localparam int          B_BOFF         = 2;     // bus-off led

    localparam int          CNT_W          = 8;
    localparam logic [CNT_W-1:0] CNT_MAX   = 8'hff;

    // fixed payload exchanged by both nodes
    localparam logic [63:0] PATTERN        = 64'h0123_4567_89ab_cdef;

    // bit rate selection handed to the controller
    typedef enum logic [1:0] {
        CPT_RATE_125  = 2'h0,
        CPT_RATE_250  = 2'h1,
        CPT_RATE_500  = 2'h2,
        CPT_RATE_1000 = 2'h3
    } cpt_rate_t;

    // raw strap pins
    typedef struct packed {
        logic role_strap;
        logic rate_strap_high;
        logic rate_strap_low;
        logic boot_strap_a;
        logic boot_strap_b;
    } cpt_straps_t;

    // controller status, same clock domain
    typedef struct packed {
        logic       rx_valid;   // one-cycle pulse, frame received
        logic [63:0] rx_data;   // payload of that frame
        logic       tx_done;    // one-cycle pulse, frame sent
        logic       err_any;    // any error status flag, level
        logic       bus_off;    // bus-off status flag, level
    } cpt_can_status_t;

    // status leds, high lights the led
    typedef struct packed {
        logic heartbeat;
        logic master;
        logic error;
        logic can_error;
        logic bus_off;
    } cpt_leds_t;

endpackage

//--- rtl/cpt_tester.sv
// sequencer for a two-node can ping-pong link test.
// assumes the attached controller runs on sys_clk and straps are raw pins.
`timescale 1ns/1ps

module cpt_tester #(
    parameter int unsigned TIMEOUT_CYC    = cpt_pkg::TIMEOUT_CYC,    // reply timeout
    parameter int unsigned HALF_BLINK_CYC = cpt_pkg::HALF_BLINK_CYC  // led half period
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire cpt_pkg::cpt_straps_t     straps,
    input  wire cpt_pkg::cpt_can_status_t can_st,
    output logic                          cfg_load,
    output cpt_pkg::cpt_rate_t            cfg_rate,
    output logic                          cfg_master,
    output logic                          boot_from_flash,
    output logic                          tx_req,
    output logic [63:0]                   tx_data,
    output logic [cpt_pkg::CNT_W-1:0]     err_count,
    output cpt_pkg::cpt_leds_t            leds
);

    // sequencer states
    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_CONFIG,
        ST_HALT,
        ST_M_SEND,
        ST_M_WAIT,
        ST_S_WAIT,
        ST_S_SEND
    } cpt_state_t;

    // one led burst: halves left and position in the current half
    typedef struct packed {
        logic [3:0]              halves;
        logic [cpt_pkg::TMR_W-1:0] cnt;
    } cpt_burst_t;

    // the whole state of the block
    typedef struct packed {
        cpt_pkg::cpt_straps_t      sync1;     // first synchroniser stage
        cpt_pkg::cpt_straps_t      sync2;     // second synchroniser stage
        logic [1:0]                settle;    // power-up settle counter
        cpt_state_t                st;
        logic                      master;    // captured role
        cpt_pkg::cpt_rate_t        rate;      // captured rate
        logic                      flash;     // captured boot mode
        logic                      load;      // config pulse
        logic [cpt_pkg::TMR_W-1:0] tmr;       // reply timer, counts down
        logic [cpt_pkg::TMR_W-1:0] hb_cnt;    // heartbeat half period
        logic                      hb;        // heartbeat level
        logic [cpt_pkg::CNT_W-1:0] errs;      // saturating error count
        cpt_burst_t [cpt_pkg::NUM_BURST-1:0] burst;
    } cpt_reg_t;

    cpt_reg_t state_q;
    cpt_reg_t state_d;

    localparam logic [cpt_pkg::TMR_W-1:0] TMO_LAST  = cpt_pkg::TMR_W'(TIMEOUT_CYC - 1);
    localparam logic [cpt_pkg::TMR_W-1:0] HALF_LAST = cpt_pkg::TMR_W'(HALF_BLINK_CYC - 1);

    // frame check is reused by both roles
    function automatic logic frame_bad(input cpt_pkg::cpt_can_status_t s);
        frame_bad = (s.rx_data != cpt_pkg::PATTERN) || s.err_any;
    endfunction

    // burst led decode shared by all three engines: lit on even halves left
    function automatic logic burst_lit(input logic [3:0] h);
        burst_lit = (h != 4'h0) && !h[0];
    endfunction

    // next-state logic
    always_comb begin
        logic [cpt_pkg::NUM_BURST-1:0] start;
        logic                          bump;
        start   = '0;
        bump    = 1'b0;
        state_d = state_q;
        state_d.load = 1'b0;

        // raw pins pass two flip-flops; only sync2 is read by logic
        state_d.sync1 = straps;
        state_d.sync2 = state_q.sync1;

        // heartbeat runs from reset, independent of the sequence
        if (state_q.hb_cnt == HALF_LAST) begin
            state_d.hb_cnt = '0;
            state_d.hb     = ~state_q.hb;
        end else begin
            state_d.hb_cnt = state_q.hb_cnt + 1'b1;
        end

        // bus-off is watched in every state but ST_SETTLE, not only on frames
        if (state_q.st != ST_SETTLE && can_st.bus_off) begin
            start[cpt_pkg::B_BOFF] = 1'b1;
        end

        unique case (state_q.st)
            // let the synchronisers fill before trusting the straps
            ST_SETTLE: begin
                if (state_q.settle == cpt_pkg::SETTLE_CYC) begin
                    state_d.st = ST_CONFIG;
                end else begin
                    state_d.settle = state_q.settle + 1'b1;
                end
            end
            // capture straps once, then configure and branch
            ST_CONFIG: begin
                state_d.master = state_q.sync2.role_strap;
                state_d.rate   = cpt_pkg::cpt_rate_t'({state_q.sync2.rate_strap_high,
                                                       state_q.sync2.rate_strap_low});
                state_d.flash  = state_q.sync2.boot_strap_a & state_q.sync2.boot_strap_b;
                if (state_q.sync2.boot_strap_a & state_q.sync2.boot_strap_b) begin
                    state_d.load = 1'b1;
                    state_d.st   = state_q.sync2.role_strap ? ST_M_SEND : ST_S_WAIT;
                    state_d.tmr  = TMO_LAST;
                end else begin
                    state_d.st = ST_HALT;
                end
            end
            // no flash image selected: the test never runs
            ST_HALT: begin
                state_d.st = ST_HALT;
            end
            // master opens every exchange
            ST_M_SEND: begin
                if (can_st.tx_done) begin
                    state_d.tmr = TMO_LAST;
                    state_d.st  = ST_M_WAIT;
                end
            end
            // master waits for the answer
            ST_M_WAIT: begin
                if (can_st.rx_valid) begin
                    if (frame_bad(can_st)) begin
                        start[cpt_pkg::B_CAN] = 1'b1;
                        bump = 1'b1;
                    end
                    state_d.st = ST_M_SEND;
                end else if (state_q.tmr == '0) begin
                    start[cpt_pkg::B_ERR] = 1'b1;
                    bump       = 1'b1;
                    state_d.st = ST_M_SEND;
                end else begin
                    state_d.tmr = state_q.tmr - 1'b1;
                end
            end
            // slave only listens here
            ST_S_WAIT: begin
                if (can_st.rx_valid) begin
                    if (frame_bad(can_st)) begin
                        start[cpt_pkg::B_CAN] = 1'b1;
                        bump = 1'b1;
                    end
                    state_d.st = ST_S_SEND;
                end else if (state_q.tmr == '0) begin
                    start[cpt_pkg::B_ERR] = 1'b1;
                    bump        = 1'b1;
                    state_d.tmr = TMO_LAST; // keep waiting
                end else begin
                    state_d.tmr = state_q.tmr - 1'b1;
                end
            end
            // slave answers once, then back to listening
            ST_S_SEND: begin
                if (can_st.tx_done) begin
                    state_d.tmr = TMO_LAST;
                    state_d.st  = ST_S_WAIT;
                end
            end
        endcase

        // saturate rather than wrap so a long soak stays readable
        if (bump && state_q.errs != cpt_pkg::CNT_MAX) begin
            state_d.errs = state_q.errs + 1'b1;
        end

        // burst engines: a start is ignored while a burst runs
        for (int i = 0; i < cpt_pkg::NUM_BURST; i++) begin
            if (state_q.burst[i].halves == '0) begin
                if (start[i]) begin
                    state_d.burst[i].halves = cpt_pkg::BURST_HALVES;
                    state_d.burst[i].cnt    = '0;
                end
            end else if (state_q.burst[i].cnt == HALF_LAST) begin
                state_d.burst[i].cnt    = '0;
                state_d.burst[i].halves = state_q.burst[i].halves - 1'b1;
            end else begin
                state_d.burst[i].cnt = state_q.burst[i].cnt + 1'b1;
            end
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs; tx_req is a handshake level held until tx_done
    assign cfg_load        = state_q.load;
    assign cfg_rate        = state_q.rate;
    assign cfg_master      = state_q.master;
    assign boot_from_flash = state_q.flash;
    assign tx_req          = (state_q.st == ST_M_SEND) || (state_q.st == ST_S_SEND);
    assign tx_data         = cpt_pkg::PATTERN;
    assign err_count       = state_q.errs;

    // burst led lit on even halves left: 8,6,4,2 on; 7,5,3,1 off
    assign leds.heartbeat  = state_q.hb;
    assign leds.master     = state_q.hb & state_q.master;
    assign leds.error      = burst_lit(state_q.burst[cpt_pkg::B_ERR].halves);
    assign leds.can_error  = burst_lit(state_q.burst[cpt_pkg::B_CAN].halves);
    assign leds.bus_off    = burst_lit(state_q.burst[cpt_pkg::B_BOFF].halves);

endmodule

//--- testbench/cpt_tester_properties.sv
// port checker for the can ping-pong tester.
// assumes straps stay steady around each cfg_load.
`timescale 1ns/1ps
module cpt_tester_props #(
    parameter int unsigned TIMEOUT_CYC    = 200,
    parameter int unsigned HALF_BLINK_CYC = 20
) (
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    input wire cpt_pkg::cpt_straps_t     straps,
    input wire cpt_pkg::cpt_can_status_t can_st,
    input wire logic                     cfg_load,
    input wire cpt_pkg::cpt_rate_t       cfg_rate,
    input wire logic                     cfg_master,
    input wire logic                     boot_from_flash,
    input wire logic                     tx_req,
    input wire logic [63:0]              tx_data,
    input wire logic [cpt_pkg::CNT_W-1:0] err_count,
    input wire cpt_pkg::cpt_leds_t       leds
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic        cfg_q, rx_q, hb_q;  // seen flags
    int unsigned wait_q, hbc_q;      // master wait, heartbeat half
    logic        bad;                // frame that must count
    assign bad = cfg_q && can_st.rx_valid && !tx_req && (can_st.rx_data != cpt_pkg::PATTERN || can_st.err_any);
    // helper registers; first toggle is skipped, its phase is free
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {cfg_q, rx_q, hb_q, wait_q, hbc_q} <= '0;
        end else begin
            cfg_q  <= cfg_q | cfg_load;
            rx_q   <= rx_q | can_st.rx_valid;
            hb_q   <= hb_q | $changed(leds.heartbeat);
            hbc_q  <= $changed(leds.heartbeat) ? 0 : hbc_q + 1;
            wait_q <= (can_st.tx_done && tx_req) ? 1 : (tx_req || can_st.rx_valid || !cfg_master) ? 0
                    : (wait_q != 0) ? wait_q + 1 : 0;
        end
    end
    a_rate_map: assert property (cfg_load |-> cfg_rate == {straps.rate_strap_high, straps.rate_strap_low})
        else $error("rate differs from straps");
    a_role_capture: assert property (cfg_load |-> cfg_master == straps.role_strap)
        else $error("role differs from strap");
    a_flash_gate: assert property (!boot_from_flash |-> !cfg_load && !tx_req)
        else $error("activity without flash boot");
    a_tx_release: assert property (tx_req && can_st.tx_done |=> !tx_req)
        else $error("tx request held after done");
    a_slave_quiet: assert property (cfg_q && !cfg_master && !rx_q |-> !tx_req)
        else $error("slave sent before any frame");
    a_rx_reply: assert property (cfg_q && can_st.rx_valid && !tx_req |=> tx_req)
        else $error("no send after received frame");
    a_bad_count: assert property (bad && err_count != 8'hff |=> err_count == $past(err_count) + 8'h1)
        else $error("bad frame not counted");
    a_err_step: assert property (err_count == $past(err_count) || err_count == $past(err_count) + 8'h1)
        else $error("error count jumped");
    a_err_sat: assert property (err_count == 8'hff |=> err_count == 8'hff)
        else $error("error count wrapped");
    a_master_led: assert property (!cfg_master |-> !leds.master)
        else $error("master led lit in slave");
    a_hb_period: assert property ($changed(leds.heartbeat) && hb_q |-> hbc_q == HALF_BLINK_CYC - 1)
        else $error("heartbeat half period wrong");
    a_retry_bound: assert property (cfg_master |-> wait_q <= TIMEOUT_CYC + 3)
        else $error("master did not retry in time");
endmodule
bind cpt_tester cpt_tester_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .HALF_BLINK_CYC(HALF_BLINK_CYC)) u_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .straps(straps), .can_st(can_st), .cfg_load(cfg_load),
    .cfg_rate(cfg_rate), .cfg_master(cfg_master), .boot_from_flash(boot_from_flash), .tx_req(tx_req),
    .tx_data(tx_data), .err_count(err_count), .leds(leds));

//--- testbench/cpt_peer.sv
// controller plus peer node in the opposite role.
// assumes the tester keeps tx_req up until tx_done.
`timescale 1ns/1ps
module cpt_peer (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic                tx_req,
    input  wire logic                reply_en,  // peer answers each frame
    input  wire logic                kick,      // peer opens an exchange
    input  wire logic                bad,       // corrupt every payload while high
    input  wire logic                err,
    input  wire logic                boff,
    input  wire logic [3:0]          dly,       // bus latency in cycles
    output cpt_pkg::cpt_can_status_t can_st
);
    logic [4:0] tx_q, rx_q;  // up-counters, rx 0 means none pending
    // pulses last one cycle; data churns outside frames
    always @(posedge sys_clk) begin
        can_st.tx_done  <= 1'b0;
        can_st.rx_valid <= 1'b0;
        can_st.rx_data  <= ~can_st.rx_data;
        can_st.err_any  <= err;
        can_st.bus_off  <= boff;
        if (!rst_n) begin
            {tx_q, rx_q, can_st.rx_data} <= '0;
        end else begin
            if (tx_req && !can_st.tx_done) begin
                tx_q <= (tx_q >= 5'(dly)) ? 5'h0 : tx_q + 5'h1;
                can_st.tx_done <= (tx_q >= 5'(dly));
                if (tx_q >= 5'(dly) && reply_en) rx_q <= 5'h1;
            end
            if (kick) begin
                rx_q <= 5'h1;
            end else if (rx_q != 5'h0) begin
                rx_q <= (rx_q > 5'(dly)) ? 5'h0 : rx_q + 5'h1;
                can_st.rx_valid <= (rx_q > 5'(dly));
                can_st.rx_data  <= bad ? ~cpt_pkg::PATTERN : cpt_pkg::PATTERN;
            end
        end
    end
endmodule

//--- testbench/cpt_tester_bench.sv
// self-checking bench for the can ping-pong tester.
// assumes short timer parameters keep the run brief.
`timescale 1ns/1ps
module cpt_tester_bench;
    localparam int unsigned TMO = 200;
    logic sys_clk, rst_n, reply_en, kick, bad, err, boff, cfg_load, cfg_master, boot_from_flash, tx_req, up, b;
    logic [3:0]  dly;
    logic [63:0] tx_data;
    logic [7:0]  err_count, exp_err;
    cpt_pkg::cpt_straps_t     straps;
    cpt_pkg::cpt_can_status_t can_st;
    cpt_pkg::cpt_rate_t       cfg_rate;
    cpt_pkg::cpt_leds_t       leds;
    int n_errors, checks, seed, i;
    cpt_tester #(.TIMEOUT_CYC(TMO), .HALF_BLINK_CYC(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .straps(straps),
        .can_st(can_st), .cfg_load(cfg_load), .cfg_rate(cfg_rate), .cfg_master(cfg_master),
        .boot_from_flash(boot_from_flash), .tx_req(tx_req), .tx_data(tx_data), .err_count(err_count), .leds(leds));
    cpt_peer peer (.sys_clk(sys_clk), .rst_n(rst_n), .tx_req(tx_req), .reply_en(reply_en), .kick(kick),
        .bad(bad), .err(err), .boff(boff), .dly(dly), .can_st(can_st));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin n_errors++; $display("ERROR %0t flag %b not %b", $time, got, exp); end
    endtask
    task chk_val(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin n_errors++; $display("ERROR %0t value %h not %h", $time, got, exp); end
    endtask
    function logic [7:0] f_sat(input logic [7:0] v, input logic inc);
        return (v == 8'hff || !inc) ? v : v + 8'h1; // saturates, never wraps
    endfunction
    // reset with a strap set, then wait briefly for configuration
    task boot(input logic [4:0] s, input int hold);
        int k;
        @(posedge sys_clk);
        rst_n  <= 1'b0;
        straps <= s;
        repeat (hold) @(posedge sys_clk);
        rst_n <= 1'b1;
        up = 1'b0;
        for (k = 0; k < 20 && !up; k++) begin @(negedge sys_clk); up = cfg_load; end
    endtask
    // next rise of tx_req, bounded
    task wait_tx;
        int k;
        up = 1'b0;
        for (k = 0; k < 600 && tx_req !== 1'b0; k++) @(negedge sys_clk);
        for (k = 0; k < 600 && !up; k++) begin @(negedge sys_clk); up = tx_req; end
    endtask
    task stop_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        stop_test;
    end
    initial begin
        {n_errors, checks, rst_n, kick, bad, err, boff, straps, exp_err} = '0;
        {seed, reply_en, dly} = {32'd2, 1'b1, 4'h1};
        // every role and rate strap setting, flash boot
        for (i = 0; i < 8; i++) begin
            boot({i[2:0], 2'b11}, (i == 0) ? 12 : 2);
            chk_bit(up, 1'b1);
            chk_bit(cfg_master, i[2]);
            chk_val({6'h0, cfg_rate}, {6'h0, i[1:0]});
            chk_bit(tx_req, i[2]);
            chk_bit(boot_from_flash, 1'b1);
            chk_bit(tx_data == cpt_pkg::PATTERN, 1'b1);
        end
        // master exchanges: good, bad payload, error flag, then random
        for (i = 0; i < 10; i++) begin
            b = (i == 1) | ((i > 2) & 1'($random(seed)));
            @(posedge sys_clk);
            {bad, err, dly} <= {b, i == 2, 4'($random(seed))};
            exp_err = f_sat(exp_err, b | (i == 2));
            wait_tx;
            chk_bit(up, 1'b1);
            chk_val(err_count, exp_err);
            if (i == 1) chk_bit(leds.can_error, 1'b1);
        end
        // silent peer: timeout, then retry
        @(posedge sys_clk);
        {reply_en, err, bad} <= 3'h0;
        wait_tx;
        chk_bit(up, 1'b1);
        chk_val(err_count, f_sat(exp_err, 1'b1));
        chk_bit(leds.error, 1'b1);
        @(posedge sys_clk) boff <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk_bit(leds.bus_off, 1'b1);
        // every frame bad, no latency: three cycles per exchange, count must stop at its top
        @(posedge sys_clk) {boff, bad, reply_en, dly} <= {1'b0, 1'b1, 1'b1, 4'h0};
        repeat (1500) @(negedge sys_clk);
        chk_val(err_count, 8'hff);
        // master indicator must light within 45 cycles, just over one heartbeat period
        up = 1'b0;
        for (i = 0; i < 45 && !up; i++) begin @(negedge sys_clk); up = leds.master; end
        chk_bit(up, 1'b1);
        // slave: quiet until a frame, then reply, then time out
        boot(5'b00011, 2);
        @(posedge sys_clk) {reply_en, dly, bad} <= {1'b1, 4'h4, 1'b0};
        repeat (50) @(negedge sys_clk);
        chk_bit(tx_req, 1'b0);
        @(posedge sys_clk) kick <= 1'b1;
        @(posedge sys_clk) kick <= 1'b0;
        wait_tx;
        chk_bit(up, 1'b1);
        wait_tx;
        chk_bit(up, 1'b1);
        @(posedge sys_clk) reply_en <= 1'b0;
        repeat (TMO + 40) @(negedge sys_clk);
        chk_val(err_count, 8'h1);
        chk_bit(tx_req, 1'b0);
        // boot straps not both high: no configuration
        boot(5'b10010, 2);
        chk_bit(up | boot_from_flash | tx_req, 1'b0);
        stop_test;
    end
endmodule
